// [hdl/irq_vector_page_stack.sv]
// Our own choices: register access over Avalon-MM and the address map.
`include "irq_vector_page_stack_consts.svh"
// Function
// - a high-priority request preempts a running low-priority routine
// - on vectoring, active page takes the source's register page
// - on vectoring, prior active page is pushed into the middle level
// - on vectoring, prior middle level is pushed into the bottom level
// - a software value in the bottom level is overwritten by a push
// - external 0 vectors to 0x0003, order 0, flag cleared on vectoring
// - external 1 vectors to 0x0013, order 2, flag cleared on vectoring
// - converter A vectors to 0x006B, order 13, flag kept on vectoring
// - converter B vectors to 0x007B, order 15, flag kept on vectoring
// - converter C vectors to 0x0093, order 18, flag kept on vectoring
module irq_vector_page_stack
   import irq_vector_page_stack_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   input  wire logic [5:0]        src_event,
   output logic                   vec_req,
   output logic [15:0]            vec_addr,
   input  wire logic              vec_ack,
   input  wire logic              vec_return,
   output logic [7:0]             active_page_select,
   output logic                   irq
);

   if (ADDR_W < 6) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   ctl_state_t s;
   ctl_state_t next_s;

   function automatic logic [15:0] vector_of(input logic [2:0] idx);
      case (idx)
         `SRC_EXT0:    vector_of = `VEC_EXT0;
         `SRC_EXT1:    vector_of = `VEC_EXT1;
         `SRC_COUNTER: vector_of = `VEC_COUNTER;
         `SRC_CONV_A:  vector_of = `VEC_CONV_A;
         `SRC_CONV_B:  vector_of = `VEC_CONV_B;
         default:      vector_of = `VEC_CONV_C;
      endcase
   endfunction : vector_of

   function automatic logic [7:0] page_of(input logic [2:0] idx);
      case (idx)
         `SRC_EXT0:    page_of = `PAGE_EXT0;
         `SRC_EXT1:    page_of = `PAGE_EXT1;
         `SRC_COUNTER: page_of = `PAGE_COUNTER;
         `SRC_CONV_A:  page_of = `PAGE_CONV_A;
         `SRC_CONV_B:  page_of = `PAGE_CONV_B;
         default:      page_of = `PAGE_CONV_C;
      endcase
   endfunction : page_of

   logic [5:0] hw_clear;
   logic [5:0] next_pending;
   logic       take;
   logic       ret;
   logic       wr;
   logic       rd_acc;
   logic [5:0] wr_pend_clr;
   logic [5:0] cand;
   logic [5:0] cand_hi;

   assign wr     = write && !s.waitrequest && byteenable[0];
   assign rd_acc = read && !s.waitrequest;
   assign take   = vec_ack && s.vec_req;
   assign ret    = vec_return && (s.in_low || s.in_high);
   assign wr_pend_clr = (wr && address[5:0] == `OFS_PENDING) ?
                        writedata[5:0] : 6'h00;

   // per-source pending flag: a new event beats any clear in the same cycle
   for (genvar i = 0; i < 6; i++) begin : g_pend
      localparam logic [2:0] IDX = 3'(i);
      assign hw_clear[i] = take && (s.vec_idx == IDX) &&
                           (((`HW_CLEAR_MASK >> i) & 6'h01) != 6'h00);
      assign next_pending[i] = src_event[i] ||
                               (s.pending[i] && !wr_pend_clr[i] &&
                                !hw_clear[i]);
   end

   always_comb begin
      logic [2:0] pick;
      logic       pick_hi;
      logic       found;
      logic       allow_low;
      logic       allow_high;
      logic [2:0] ev;
      pick      = 3'h0;
      pick_hi   = 1'b0;
      found     = 1'b0;
      allow_low = 1'b0;
      allow_high = 1'b0;
      ev        = 3'h0;
      cand      = 6'h00;
      cand_hi   = 6'h00;
      next_s    = s;

      // bus: one wait cycle, then the request is accepted
      next_s.waitrequest = !((read || write) && s.waitrequest);
      if ((read || write) && s.waitrequest) begin
         case (address[5:0])
            `OFS_CTRL:     next_s.readdata = {31'h0, s.gie};
            `OFS_ENABLE:   next_s.readdata = {26'h0, s.enable};
            `OFS_PRIO:     next_s.readdata = {26'h0, s.high_prio};
            `OFS_PENDING:  next_s.readdata = {26'h0, s.pending};
            `OFS_PAGE_ACT: next_s.readdata = {24'h0, s.page_active};
            `OFS_PAGE_MID: next_s.readdata = {24'h0, s.page_middle};
            `OFS_PAGE_BOT: next_s.readdata = {24'h0, s.page_bottom};
            `OFS_STATUS:   next_s.readdata = {29'h0, s.status};
            `OFS_MASK:     next_s.readdata = {29'h0, s.mask};
            `OFS_STATE:    next_s.readdata = {26'h0, s.vec_idx,
                                              s.vec_req, s.in_high,
                                              s.in_low};
            default:       next_s.readdata = 32'h0;
         endcase
      end

      if (wr) begin
         case (address[5:0])
            `OFS_CTRL:     next_s.gie = writedata[0];
            `OFS_ENABLE:   next_s.enable = writedata[5:0];
            `OFS_PRIO:     next_s.high_prio = writedata[5:0];
            `OFS_PAGE_ACT: next_s.page_active = writedata[7:0];
            `OFS_PAGE_MID: next_s.page_middle = writedata[7:0];
            `OFS_PAGE_BOT: next_s.page_bottom = writedata[7:0];
            `OFS_MASK:     next_s.mask = writedata[2:0];
            default:       ;
         endcase
      end

      next_s.pending = next_pending;

      // a push overrides a software write to the stack in the same cycle
      if (take) begin
         next_s.page_active = page_of(s.vec_idx);
         next_s.page_middle = s.page_active;
         next_s.page_bottom = s.page_middle;
         if (s.vec_high) begin
            next_s.in_high = 1'b1;
         end else begin
            next_s.in_low = 1'b1;
         end
      end else if (ret) begin
         next_s.page_active = s.page_middle;
         next_s.page_middle = s.page_bottom;
         if (s.in_high) begin
            next_s.in_high = 1'b0;
         end else begin
            next_s.in_low = 1'b0;
         end
      end

      // both enables gate every source, counter array included
      cand    = next_s.pending & next_s.enable & {6{next_s.gie}};
      cand_hi = cand & next_s.high_prio;
      allow_high = !next_s.in_high;
      allow_low  = !next_s.in_high && !next_s.in_low;
      // indices are sorted by order number, so downward scan ends lowest
      for (int i = 5; i >= 0; i--) begin
         if (allow_low && cand[i] && !cand_hi[i]) begin
            pick    = 3'(i);
            pick_hi = 1'b0;
            found   = 1'b1;
         end
      end
      for (int i = 5; i >= 0; i--) begin
         if (allow_high && cand_hi[i]) begin
            pick    = 3'(i);
            pick_hi = 1'b1;
            found   = 1'b1;
         end
      end
      next_s.vec_req  = found;
      next_s.vec_idx  = pick;
      next_s.vec_high = pick_hi;
      next_s.vec_addr = found ? vector_of(pick) : 16'h0000;

      ev[`ST_VECTORED] = take;
      ev[`ST_PREEMPT]  = take && s.vec_high && s.in_low;
      ev[`ST_RETURN]   = ret;
      // read clears only the bits it reported, so a late event survives
      if (rd_acc && address[5:0] == `OFS_STATUS) begin
         next_s.status = (s.status & ~s.readdata[2:0]) | ev;
      end else begin
         next_s.status = s.status | ev;
      end
      next_s.irq = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s             <= '0;
         s.waitrequest <= 1'b1;
         s.page_active <= `RST_PAGE;
         s.page_middle <= `RST_PAGE;
         s.page_bottom <= `RST_PAGE;
      end else begin
         s <= next_s;
      end
   end

   assign readdata           = s.readdata;
   assign waitrequest        = s.waitrequest;
   assign vec_req            = s.vec_req;
   assign vec_addr           = s.vec_addr;
   assign active_page_select = s.page_active;
   assign irq                = s.irq;

   logic sw_pend_clr_any;
   assign sw_pend_clr_any = |wr_pend_clr;

   property p_preempt;
      @(posedge clk) disable iff (rst)
      take && s.vec_high && s.in_low && !s.in_high
      |=> s.in_high && s.in_low;
   endproperty
   a_preempt: assert property (p_preempt)
      else $error("high request did not preempt low routine");

   property p_page_load;
      @(posedge clk) disable iff (rst)
      take |=> active_page_select == page_of($past(s.vec_idx));
   endproperty
   a_page_load: assert property (p_page_load)
      else $error("active page not loaded with source page");

   property p_push_middle;
      @(posedge clk) disable iff (rst)
      take |=> s.page_middle == $past(s.page_active);
   endproperty
   a_push_middle: assert property (p_push_middle)
      else $error("middle level did not receive prior active page");

   property p_push_bottom;
      @(posedge clk) disable iff (rst)
      take |=> s.page_bottom == $past(s.page_middle);
   endproperty
   a_push_bottom: assert property (p_push_bottom)
      else $error("bottom level did not receive prior middle");

   property p_bottom_overwrite;
      @(posedge clk) disable iff (rst)
      take && wr && address[5:0] == `OFS_PAGE_BOT
      |=> s.page_bottom == $past(s.page_middle);
   endproperty
   a_bottom_overwrite: assert property (p_bottom_overwrite)
      else $error("software bottom value survived a push");

   property p_ext0;
      @(posedge clk) disable iff (rst)
      take && s.vec_idx == `SRC_EXT0 && !src_event[0]
      |-> vec_addr == `VEC_EXT0 ##1 !s.pending[0];
   endproperty
   a_ext0: assert property (p_ext0)
      else $error("external 0 vector or hardware clear wrong");

   property p_ext1;
      @(posedge clk) disable iff (rst)
      take && s.vec_idx == `SRC_EXT1 && !src_event[1]
      |-> vec_addr == `VEC_EXT1 ##1 !s.pending[1];
   endproperty
   a_ext1: assert property (p_ext1)
      else $error("external 1 vector or hardware clear wrong");

   property p_conv_a;
      @(posedge clk) disable iff (rst)
      take && s.vec_idx == `SRC_CONV_A && !sw_pend_clr_any
      |-> vec_addr == `VEC_CONV_A ##1 s.pending[3];
   endproperty
   a_conv_a: assert property (p_conv_a)
      else $error("converter A vector wrong or flag cleared");

   property p_conv_b;
      @(posedge clk) disable iff (rst)
      take && s.vec_idx == `SRC_CONV_B && !sw_pend_clr_any
      |-> vec_addr == `VEC_CONV_B ##1 s.pending[4];
   endproperty
   a_conv_b: assert property (p_conv_b)
      else $error("converter B vector wrong or flag cleared");

   property p_conv_c;
      @(posedge clk) disable iff (rst)
      take && s.vec_idx == `SRC_CONV_C && !sw_pend_clr_any
      |-> vec_addr == `VEC_CONV_C ##1 s.pending[5];
   endproperty
   a_conv_c: assert property (p_conv_c)
      else $error("converter C vector wrong or flag cleared");

   property p_pop;
      @(posedge clk) disable iff (rst)
      ret && !take |=> s.page_active == $past(s.page_middle) &&
                       s.page_middle == $past(s.page_bottom);
   endproperty
   a_pop: assert property (p_pop)
      else $error("return did not pop the page stack");

   property p_lowest_first;
      @(posedge clk) disable iff (rst)
      s.vec_req && !s.vec_high && $stable(s.pending) && $stable(s.enable)
      |-> ((s.pending & s.enable & ~s.high_prio) &
           ((6'h01 << s.vec_idx) - 6'h01)) == 6'h00;
   endproperty
   a_lowest_first: assert property (p_lowest_first)
      else $error("a lower order request was passed over");

   c_preempt: cover property (@(posedge clk) disable iff (rst)
      take && s.vec_high && s.in_low);
   c_nested_return: cover property (@(posedge clk) disable iff (rst)
      ret && s.in_high && s.in_low);
   c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));

endmodule : irq_vector_page_stack

// [hdl/irq_vector_page_stack_consts.svh]
`ifndef IRQ_VECTOR_PAGE_STACK_CONSTS_SVH
`define IRQ_VECTOR_PAGE_STACK_CONSTS_SVH

// register byte offsets
`define OFS_CTRL      6'h00
`define OFS_ENABLE    6'h04
`define OFS_PRIO      6'h08
`define OFS_PENDING   6'h0C
`define OFS_PAGE_ACT  6'h10
`define OFS_PAGE_MID  6'h14
`define OFS_PAGE_BOT  6'h18
`define OFS_STATUS    6'h1C
`define OFS_MASK      6'h20
`define OFS_STATE     6'h24

// source indices, ordered by priority order
`define SRC_EXT0      3'h0
`define SRC_EXT1      3'h1
`define SRC_COUNTER   3'h2
`define SRC_CONV_A    3'h3
`define SRC_CONV_B    3'h4
`define SRC_CONV_C    3'h5

// vector addresses
`define VEC_EXT0      16'h0003
`define VEC_EXT1      16'h0013
`define VEC_COUNTER   16'h004B
`define VEC_CONV_A    16'h006B
`define VEC_CONV_B    16'h007B
`define VEC_CONV_C    16'h0093

// priority order numbers
`define ORD_EXT0      5'h00
`define ORD_EXT1      5'h02
`define ORD_COUNTER   5'h09
`define ORD_CONV_A    5'h0D
`define ORD_CONV_B    5'h0F
`define ORD_CONV_C    5'h12

// register page holding each source's registers
`define PAGE_EXT0     8'h00
`define PAGE_EXT1     8'h00
`define PAGE_COUNTER  8'h00
`define PAGE_CONV_A   8'h00
`define PAGE_CONV_B   8'h01
`define PAGE_CONV_C   8'h02

// sources whose pending flag hardware clears on vectoring
`define HW_CLEAR_MASK 6'h03

// status bit positions and reset values
`define ST_VECTORED   0
`define ST_PREEMPT    1
`define ST_RETURN     2
`define RST_PAGE      8'h00

`endif

// [hdl/irq_vector_page_stack_pkg.sv]
package irq_vector_page_stack_pkg;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
      logic        gie;
      logic [5:0]  enable;
      logic [5:0]  high_prio;
      logic [5:0]  pending;
      logic [7:0]  page_active;
      logic [7:0]  page_middle;
      logic [7:0]  page_bottom;
      logic [2:0]  status;
      logic [2:0]  mask;
      logic        irq;
      logic        vec_req;
      logic [2:0]  vec_idx;
      logic        vec_high;
      logic [15:0] vec_addr;
      logic        in_low;
      logic        in_high;
   } ctl_state_t;

endpackage : irq_vector_page_stack_pkg

// [tb/cpu_core_model.sv]
module cpu_core_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       vec_req,
   input  wire logic [3:0] ack_wait,
   input  wire logic       ret_cmd,
   output logic            vec_ack,
   output logic            vec_return
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   // a slow core lets the request stand a few cycles before taking it
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt        <= 4'h0;
         vec_ack    <= 1'b0;
         vec_return <= 1'b0;
      end else begin
         vec_return <= ret_cmd;
         vec_ack    <= 1'b0;
         cnt        <= 4'h0;
         if (vec_req && !vec_ack) begin
            if (cnt >= ack_wait)
               vec_ack <= 1'b1;
            else
               cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : cpu_core_model

// [tb/test_irq_vector_page_stack.sv]
`include "irq_vector_page_stack_consts.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
$display("wrong value at %0t: got %h want %h", $time, a, e); end end
module test_irq_vector_page_stack;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk        = 1'b0;
   logic        rst        = 1'b1;
   logic [5:0]  address    = 6'h00;
   logic        read       = 1'b0;
   logic        write      = 1'b0;
   logic [31:0] writedata  = 32'h0;
   logic [3:0]  byteenable = 4'hF;
   logic [5:0]  src_event  = 6'h00;
   logic [3:0]  ack_wait   = 4'h0;
   logic        ret_cmd    = 1'b0;
   logic        pg_due     = 1'b0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        vec_req;
   logic [15:0] vec_addr;
   logic        vec_ack;
   logic        vec_return;
   logic [7:0]  active_page_select;
   logic        irq;
   logic [7:0]  pg_exp;
   logic [31:0] e_rd;
   logic [23:0] e_vec;
   logic [31:0] exp_rd[$];
   logic [23:0] exp_vec[$];
   int          n_fail = 0;
   int          checks = 0;
   int          seed   = 62;
   logic [15:0] vtab [6] = '{`VEC_EXT0, `VEC_EXT1, `VEC_COUNTER,
                             `VEC_CONV_A, `VEC_CONV_B, `VEC_CONV_C};
   logic [7:0]  ptab [6] = '{`PAGE_EXT0, `PAGE_EXT1, `PAGE_COUNTER,
                             `PAGE_CONV_A, `PAGE_CONV_B, `PAGE_CONV_C};

   initial forever #2 clk = ~clk;

   irq_vector_page_stack i_irq_vector_page_stack (
      .clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .src_event(src_event), .vec_req(vec_req), .vec_addr(vec_addr),
      .vec_ack(vec_ack), .vec_return(vec_return),
      .active_page_select(active_page_select), .irq(irq));

   cpu_core_model i_cpu_core_model (
      .clk(clk), .rst(rst), .vec_req(vec_req), .ack_wait(ack_wait),
      .ret_cmd(ret_cmd), .vec_ack(vec_ack), .vec_return(vec_return));

   // page is checked one edge after the take, when the push has landed
   always @(posedge clk) begin
      if (pg_due) begin
         `CHK(active_page_select, pg_exp)
         pg_due <= 1'b0;
      end
      if (read && !waitrequest) begin
         e_rd = (exp_rd.size() > 0) ? exp_rd.pop_front() : 32'hDEADBEEF;
         `CHK(readdata, e_rd)
      end
      if (vec_req && vec_ack) begin
         e_vec = (exp_vec.size() > 0) ? exp_vec.pop_front() : 24'hFFFFFF;
         `CHK(vec_addr, e_vec[23:8])
         pg_exp <= e_vec[7:0];
         pg_due <= 1'b1;
      end
   end

   task automatic results();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      address    <= a;
      writedata  <= d;
      byteenable <= be;
      read       <= !w;
      write      <= w;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      `CHK(n < 50, 1'b1)
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, 4'hF);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask : rd

   task automatic fire(input logic [5:0] m);
      @(posedge clk);
      src_event <= m;
      @(posedge clk);
      src_event <= 6'h00;
   endtask : fire

   task automatic ret();
      @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : ret

   task automatic wait_vec(input int left);
      int n;
      n = 0;
      while ((exp_vec.size() > left || pg_due) && n < 60) begin
         @(posedge clk);
         n++;
      end
      `CHK(n < 60, 1'b1)
   endtask : wait_vec

   initial begin
      #(20000 * 4);
      n_fail++;
      results();
   end

   initial begin
      logic [7:0] pg;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(`OFS_PAGE_ACT, 32'h0);
      rd(`OFS_CTRL, 32'h0);
      rd(6'h3C, 32'h0);
      wr(6'h3C, 8'hFF);
      // low byte lane off: the write must not land
      bus(1'b1, `OFS_CTRL, 32'h1, 4'hE);
      rd(`OFS_CTRL, 32'h0);
      wr(`OFS_CTRL, 8'h01);
      for (int i = 0; i < 6; i++) begin
         pg = 8'($random(seed));
         wr(`OFS_ENABLE, 8'h01 << i);
         wr(`OFS_PAGE_ACT, pg);
         exp_vec.push_back({vtab[i], ptab[i]});
         fire(6'h01 << i);
         wait_vec(0);
         rd(`OFS_PAGE_MID, {24'h0, pg});
         rd(`OFS_PENDING, i < 2 ? 32'h0 : 32'h1 << i);
         wr(`OFS_PENDING, 8'h01 << i);
         ret();
         rd(`OFS_PAGE_ACT, {24'h0, pg});
      end
      ack_wait <= 4'h3;
      wr(`OFS_CTRL, 8'h00);
      wr(`OFS_ENABLE, 8'h04);
      fire(6'h04);
      repeat (8) @(posedge clk);
      `CHK(vec_req, 1'b0)
      exp_vec.push_back({`VEC_COUNTER, `PAGE_COUNTER});
      wr(`OFS_CTRL, 8'h01);
      wait_vec(0);
      wr(`OFS_PENDING, 8'h04);
      ret();
      rd(`OFS_STATUS, 32'h5);
      wr(`OFS_MASK, 8'h02);
      wr(`OFS_ENABLE, 8'h24);
      wr(`OFS_PRIO, 8'h04);
      wr(`OFS_PAGE_MID, 8'h0F);
      wr(`OFS_PAGE_BOT, 8'h5A);
      pg = 8'($random(seed));
      wr(`OFS_PAGE_ACT, pg);
      exp_vec.push_back({`VEC_CONV_C, `PAGE_CONV_C});
      fire(6'h20);
      wait_vec(0);
      rd(`OFS_PAGE_BOT, 32'h0F);
      `CHK(irq, 1'b0)
      wr(`OFS_PENDING, 8'h20);
      exp_vec.push_back({`VEC_COUNTER, `PAGE_COUNTER});
      fire(6'h04);
      wait_vec(0);
      rd(`OFS_PAGE_MID, {24'h0, `PAGE_CONV_C});
      rd(`OFS_PAGE_BOT, {24'h0, pg});
      rd(`OFS_STATE, 32'h3);
      `CHK(irq, 1'b1)
      rd(`OFS_STATUS, 32'h3);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      wr(`OFS_PENDING, 8'h04);
      ret();
      rd(`OFS_PAGE_ACT, {24'h0, `PAGE_CONV_C});
      rd(`OFS_PAGE_MID, {24'h0, pg});
      ret();
      rd(`OFS_PAGE_ACT, {24'h0, pg});
      wr(`OFS_PRIO, 8'h00);
      wr(`OFS_ENABLE, 8'h03);
      exp_vec.push_back({`VEC_EXT0, `PAGE_EXT0});
      exp_vec.push_back({`VEC_EXT1, `PAGE_EXT1});
      fire(6'h03);
      wait_vec(1);
      ret();
      wait_vec(0);
      ret();
      results();
   end
endmodule : test_irq_vector_page_stack
